// ---- rtl/gpw_port.sv ----
// GPIO port top with APB registers, command queue and change wait
// Function
// R01: Zero direction bit input, nonzero bit output
// R02: Directions reset to all inputs
// R03: Port disabled until configuration enables it
// R04: Input read bit set means line high
// R05: Outputs, disabled or serial lines read zero
// R06: Output values latched, drive once line enabled
// R07: Directions latched for serial lines, applied later
// R08: Output mask drives lines high or low
// R09: Availability mask shows usable port lines
// R10: Wait ends on enabled input line change
// R11: Wait timeout in milliseconds, about sixty seconds
// R12: Expiry still returns present input state
// R13: First wait after reconfiguration returns immediately
// R14: Host compares results with own copy
// R15: Queued commands run only at submission
// R16: Line n maps to bit n everywhere
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module gpw_port
  import gpw_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [31:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  output logic              irq,
  input  wire gpw_mask_type line_in,
  output gpw_mask_type      line_out,
  output gpw_mask_type      line_oe
);

  typedef struct packed {
    logic                           enable;
    gpw_mask_type                   serial;
    gpw_mask_type                   dir;
    gpw_mask_type                   outv;
    gpw_mask_type                   wait_res;
    logic [1:0]                     stat;
    logic [1:0]                     mask;
    logic                           first;
    gpw_qent_type [QDEPTH-1:0]      q;
    logic [QPTR_W-1:0]              qwr;
    logic [QPTR_W-1:0]              qrd;
    logic [QCNT_W-1:0]              qcnt;
    gpw_mask_type [QDEPTH-1:0]      rq;
    logic [QPTR_W-1:0]              rwr;
    logic [QPTR_W-1:0]              rrd;
    logic [QCNT_W-1:0]              rcnt;
    gpw_eng_type                    eng;
    logic                           from_q;
    logic                           pready;
    logic                           pslverr;
    logic [31:0]                    prdata;
    logic                           irq;
    gpw_mask_type                   line_out;
    gpw_mask_type                   line_oe;
  } gpw_state_type;

  gpw_state_type s_ff;
  gpw_state_type nxt_s;

  localparam logic [QCNT_W-1:0] QFULL = QCNT_W'(QDEPTH);
  localparam logic [QCNT_W-1:0] CNT1  = QCNT_W'(1);
  localparam logic [QPTR_W-1:0] PTR1  = QPTR_W'(1);

  logic         w_start;
  logic         w_imm;
  logic [15:0]  w_limit;
  logic         w_busy;
  logic         w_done;
  gpw_mask_type w_result;
  gpw_mask_type view;
  logic         acc;
  logic         fire;
  logic [7:0]   addr;
  logic [1:0]   ev;
  logic         rd_pop;
  gpw_qent_type cur;

  // R16: bit n is line n
  // R05: masked input view shared by read, get and wait
  assign view = gpw_view(s_ff.enable, s_ff.serial, s_ff.dir, line_in);
  assign addr = paddr[7:0];
  assign acc  = psel && penable && !s_ff.pready;
  assign fire = psel && penable && s_ff.pready;
  assign cur  = s_ff.q[s_ff.qrd];

  // ************************************************************
  // Waiter
  // ************************************************************
  gpw_waiter #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_waiter (
    .pclk      (pclk),
    .presetn   (presetn),
    .start     (w_start),
    .immediate (w_imm),
    .limit_ms  (w_limit),
    .view      (view),
    .busy      (w_busy),
    .done      (w_done),
    .result    (w_result)
  );

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    nxt_s         = s_ff;
    ev            = 2'b00;
    w_start       = 1'b0;
    w_imm         = s_ff.first;
    w_limit       = pwdata[15:0];
    rd_pop        = 1'b0;
    nxt_s.pready  = 1'b0;
    nxt_s.pslverr = 1'b0;

    // APB access phase, answer one cycle later
    if (acc) begin
      nxt_s.pready = 1'b1;
      nxt_s.prdata = '0;
      unique case (addr)
        A_CFG:    nxt_s.prdata[CFG_EN_BIT] = s_ff.enable;
        A_SERIAL: nxt_s.prdata[15:0] = s_ff.serial;
        A_DIR:    nxt_s.prdata[15:0] = s_ff.dir;
        A_OUT:    nxt_s.prdata[15:0] = s_ff.outv;
        // R04: high line reads as one
        A_IN:     nxt_s.prdata[15:0] = view;
        // R09: availability mask
        A_AVAIL:  nxt_s.prdata[15:0] = gpw_avail(s_ff.enable, s_ff.serial);
        A_WAIT: begin
          nxt_s.prdata[15:0] = s_ff.wait_res;
          nxt_s.pslverr      = pwrite && (s_ff.eng != E_IDLE);
        end
        A_STAT:   nxt_s.prdata[1:0] = s_ff.stat;
        A_MASK:   nxt_s.prdata[1:0] = s_ff.mask;
        A_QPUSH: begin
          nxt_s.prdata[QCNT_W-1:0] = s_ff.qcnt;
          nxt_s.prdata[QSTAT_BUSY] = (s_ff.eng != E_IDLE);
          nxt_s.pslverr            = pwrite && (s_ff.qcnt == QFULL);
        end
        A_QSUB:   nxt_s.prdata = '0;
        A_QRESP: begin
          nxt_s.prdata[15:0]       = s_ff.rq[s_ff.rrd];
          nxt_s.prdata[RESP_VALID] = (s_ff.rcnt != '0);
        end
        default:  nxt_s.pslverr = 1'b1;
      endcase
    end

    // Effects at the edge where pready is sampled
    if (fire && pwrite && !s_ff.pslverr) begin
      unique case (addr)
        A_CFG: begin
          // R03: port stays off until enabled here
          nxt_s.enable = pwdata[CFG_EN_BIT];
          nxt_s.first  = 1'b1;
        end
        A_SERIAL: begin
          nxt_s.serial = pwdata[15:0];
          nxt_s.first  = 1'b1;
        end
        A_DIR: begin
          // R01: nonzero bit selects output
          nxt_s.dir   = pwdata[15:0];
          nxt_s.first = 1'b1;
        end
        // R06: value latched, unless a queued Q_OUT writes outv in the same cycle
        A_OUT:  nxt_s.outv = pwdata[15:0];
        A_WAIT: begin
          w_start      = 1'b1;
          nxt_s.first  = 1'b0;
          nxt_s.from_q = 1'b0;
          nxt_s.eng    = E_WAIT;
        end
        A_MASK: nxt_s.mask = pwdata[1:0];
        A_QPUSH: begin
          // R15: command only stored here
          nxt_s.q[s_ff.qwr] = gpw_qent_type'(pwdata[QOP_LSB+1:0]);
          nxt_s.qwr         = s_ff.qwr + PTR1;
          nxt_s.qcnt        = s_ff.qcnt + CNT1;
        end
        A_QSUB: begin
          if (s_ff.eng == E_IDLE) begin
            nxt_s.eng = E_RUN;
          end
        end
        default: nxt_s.eng = nxt_s.eng;
      endcase
    end
    if (fire && !pwrite && addr == A_QRESP && s_ff.rcnt != '0) begin
      rd_pop = 1'b1;
    end

    // ************************************************************
    // Command engine
    // ************************************************************
    unique case (s_ff.eng)
      E_IDLE: nxt_s.eng = nxt_s.eng;
      E_RUN: begin
        if (s_ff.qcnt == '0) begin
          nxt_s.eng = E_IDLE;
          ev[ST_QUEUE] = 1'b1;
        end else begin
          nxt_s.qrd  = s_ff.qrd + PTR1;
          nxt_s.qcnt = nxt_s.qcnt - CNT1;
          // R15: queued commands executed at submission
          unique case (cur.op)
            Q_DIR: begin
              nxt_s.dir   = cur.data;
              nxt_s.first = 1'b1;
            end
            Q_OUT: nxt_s.outv = cur.data;
            Q_GET: begin
              nxt_s.rq[nxt_s.rwr] = view;
              nxt_s.rwr           = nxt_s.rwr + PTR1;
              nxt_s.rcnt          = nxt_s.rcnt + CNT1;
            end
            Q_CHG: begin
              w_start      = 1'b1;
              w_limit      = cur.data;
              nxt_s.first  = 1'b0;
              nxt_s.from_q = 1'b1;
              nxt_s.eng    = E_WAIT;
            end
          endcase
        end
      end
      E_WAIT: begin
        if (w_done) begin
          if (s_ff.from_q) begin
            // R15: result goes to response collection
            nxt_s.rq[nxt_s.rwr] = w_result;
            nxt_s.rwr           = nxt_s.rwr + PTR1;
            nxt_s.rcnt          = nxt_s.rcnt + CNT1;
            nxt_s.eng           = E_RUN;
          end else begin
            nxt_s.wait_res = w_result;
            ev[ST_WAIT]    = 1'b1;
            nxt_s.eng      = E_IDLE;
          end
        end
      end
      default: nxt_s.eng = E_IDLE;
    endcase

    if (rd_pop) begin
      nxt_s.rrd  = s_ff.rrd + PTR1;
      nxt_s.rcnt = nxt_s.rcnt - CNT1;
    end
    // Full response queue drops its oldest entry
    if (nxt_s.rcnt > QFULL) begin
      nxt_s.rrd  = nxt_s.rrd + PTR1;
      nxt_s.rcnt = QFULL;
    end

    // Sticky status, set wins over write-one clear
    if (fire && pwrite && addr == A_STAT) begin
      nxt_s.stat = s_ff.stat & ~pwdata[1:0];
    end
    nxt_s.stat = nxt_s.stat | ev;
    nxt_s.irq  = |(nxt_s.stat & nxt_s.mask);

    // R07: direction applies only on available lines
    nxt_s.line_oe  = nxt_s.dir & gpw_avail(nxt_s.enable, nxt_s.serial);
    // R08: latched mask drives enabled outputs
    nxt_s.line_out = nxt_s.outv;
  end

  // R02: all inputs and port off after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff     <= '0;
      s_ff.dir <= DIR_RESET;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign prdata   = s_ff.prdata;
  assign pready   = s_ff.pready;
  assign pslverr  = s_ff.pslverr;
  assign irq      = s_ff.irq;
  assign line_out = s_ff.line_out;
  assign line_oe  = s_ff.line_oe;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_oe_dir: assert property ( // R01
    (line_oe & ~s_ff.dir) == LINES_ZERO)
    else $error("output enabled on an input line");
  chk_port_off: assert property ( // R03
    !s_ff.enable |-> line_oe == LINES_ZERO)
    else $error("line driven while port disabled");
  chk_in_high: assert property ( // R04
    (acc && !pwrite && addr == A_IN) |=> (prdata[15:0] & ~$past(line_in)) == LINES_ZERO)
    else $error("low line read as high");
  chk_in_masked: assert property ( // R05
    (acc && !pwrite && addr == A_IN) |=> (prdata[15:0] & $past(s_ff.dir)) == LINES_ZERO)
    else $error("output line read as input");
  chk_out_latch: assert property ( // R06
    (fire && pwrite && addr == A_OUT && s_ff.eng == E_IDLE) |=> line_out == $past(pwdata[15:0]))
    else $error("output value not latched");
  chk_serial_hold: assert property ( // R07
    (line_oe & s_ff.serial) == LINES_ZERO)
    else $error("serial line driven by port");
  chk_ready_pulse: assert property (
    acc |=> pready ##1 !pready)
    else $error("apb answer not one cycle");
  chk_queue_hold: assert property ( // R15
    (s_ff.eng == E_IDLE && !(fire && pwrite && addr == A_QSUB)) |=> s_ff.qcnt >= $past(s_ff.qcnt))
    else $error("queue ran without submission");
  chk_irq_level: assert property (
    (|(s_ff.stat & s_ff.mask)) |-> irq)
    else $error("interrupt missing");

  cov_queue_run: cover property (s_ff.eng == E_RUN ##1 s_ff.eng == E_WAIT);
  cov_wait_done: cover property ($rose(s_ff.stat[ST_WAIT]));
  cov_resp_pop: cover property (rd_pop);

endmodule : gpw_port
`default_nettype wire

// ---- rtl/gpw_pkg.sv ----
// Shared constants and types of the GPIO port with change wait
package gpw_pkg;

  // ************************************************************
  // Sizes and timing
  // ************************************************************
  localparam int          NLINES      = 16;
  localparam int          QDEPTH      = 4;
  localparam int          QPTR_W      = 2;
  localparam int          QCNT_W      = 3;
  localparam int          CLK_NS      = 50;
  localparam int          MS_NS       = 1000000;
  localparam int          TICK_CYC    = MS_NS / CLK_NS;
  localparam int          TICK_W      = 16;
  localparam logic [15:0] WAIT_MAX_MS = 16'hEA60;

  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [7:0] A_CFG    = 8'h00;
  localparam logic [7:0] A_SERIAL = 8'h04;
  localparam logic [7:0] A_DIR    = 8'h08;
  localparam logic [7:0] A_OUT    = 8'h0C;
  localparam logic [7:0] A_IN     = 8'h10;
  localparam logic [7:0] A_AVAIL  = 8'h14;
  localparam logic [7:0] A_WAIT   = 8'h18;
  localparam logic [7:0] A_STAT   = 8'h1C;
  localparam logic [7:0] A_MASK   = 8'h20;
  localparam logic [7:0] A_QPUSH  = 8'h24;
  localparam logic [7:0] A_QSUB   = 8'h28;
  localparam logic [7:0] A_QRESP  = 8'h2C;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int          CFG_EN_BIT  = 0;
  localparam int          ST_WAIT     = 0;
  localparam int          ST_QUEUE    = 1;
  localparam int          QOP_LSB     = 16;
  localparam int          RESP_VALID  = 16;
  localparam int          QSTAT_BUSY  = 3;
  localparam logic [15:0] DIR_RESET   = 16'h0000;
  localparam logic [15:0] LINES_ZERO  = 16'h0000;

  typedef logic [NLINES-1:0] gpw_mask_type;

  typedef enum logic [1:0] {
    Q_DIR,
    Q_OUT,
    Q_GET,
    Q_CHG
  } gpw_qop_type;

  typedef enum logic [1:0] {
    E_IDLE,
    E_RUN,
    E_WAIT
  } gpw_eng_type;

  typedef struct packed {
    gpw_qop_type  op;
    gpw_mask_type data;
  } gpw_qent_type;

  // Usable lines: port enabled and not owned by a serial subsystem
  function automatic gpw_mask_type gpw_avail(logic en, gpw_mask_type serial);
    return en ? ~serial : LINES_ZERO;
  endfunction

  // Input view: high lines that are available inputs
  function automatic gpw_mask_type gpw_view(logic en, gpw_mask_type serial,
                                            gpw_mask_type dir, gpw_mask_type lines);
    return lines & ~dir & gpw_avail(en, serial);
  endfunction

endpackage : gpw_pkg

// ---- rtl/gpw_waiter.sv ----
// Change-wait engine with millisecond timeout
`timescale 1ns/100ps
`default_nettype none
module gpw_waiter
  import gpw_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         start,
  input  wire logic         immediate,
  input  wire logic [15:0]  limit_ms,
  input  wire gpw_mask_type view,
  output logic              busy,
  output logic              done,
  output gpw_mask_type      result
);

  typedef struct packed {
    logic              busy;
    logic              done;
    logic [15:0]       ms_left;
    logic [TICK_W-1:0] tick;
    gpw_mask_type      snap;
    gpw_mask_type      result;
  } gpw_wstate_type;

  gpw_wstate_type s_ff;
  gpw_wstate_type nxt_s;

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  always_comb begin
    nxt_s      = s_ff;
    nxt_s.done = 1'b0;
    if (start && !s_ff.busy) begin
      // R13: first wait returns at once
      if (immediate) begin
        nxt_s.done   = 1'b1;
        nxt_s.result = view;
      end else begin
        nxt_s.busy    = 1'b1;
        nxt_s.snap    = view;
        nxt_s.tick    = '0;
        // R11: limit in ms, clamped
        nxt_s.ms_left = (limit_ms > WAIT_MAX_MS) ? WAIT_MAX_MS : limit_ms;
      end
    end else if (s_ff.busy) begin
      // R10: any watched input change ends the wait
      if (view != s_ff.snap) begin
        nxt_s.busy   = 1'b0;
        nxt_s.done   = 1'b1;
        nxt_s.result = view;
      end else if (s_ff.tick == TICK_LAST) begin
        nxt_s.tick = '0;
        // R12: expiry returns present state
        if (s_ff.ms_left == 16'h0000) begin
          nxt_s.busy   = 1'b0;
          nxt_s.done   = 1'b1;
          nxt_s.result = view;
        end else begin
          nxt_s.ms_left = s_ff.ms_left - 16'h0001;
        end
      end else begin
        nxt_s.tick = s_ff.tick + TICK_W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign busy   = s_ff.busy;
  assign done   = s_ff.done;
  assign result = s_ff.result;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_change_ends: assert property ( // R10
    (s_ff.busy && !start && view != s_ff.snap) |=> (done && !busy && result == $past(view)))
    else $error("change did not end the wait");
  chk_immediate_done: assert property ( // R13
    (start && immediate && !busy) |=> (done && !busy))
    else $error("immediate wait did not complete");
  chk_limit_bound: assert property ( // R11
    busy |-> (s_ff.ms_left <= WAIT_MAX_MS))
    else $error("wait limit above maximum");
  cov_timeout: cover property ($fell(busy) && s_ff.ms_left == 16'h0000);

endmodule : gpw_waiter
`default_nettype wire

// ---- verif/gpw_lines_model.sv ----
// Target-side line model facing the GPIO port
`timescale 1ns/100ps
`default_nettype none
module gpw_lines_model
  import gpw_pkg::*;
(
  input  wire gpw_mask_type line_out,
  input  wire gpw_mask_type line_oe,
  input  wire gpw_mask_type ext_val,
  output gpw_mask_type      line_in
);
  // ************************************************************
  // Wire level of every line
  // ************************************************************
  // line n on bit n
  always_comb begin
    line_in = (line_out & line_oe) | (ext_val & ~line_oe);
  end
endmodule : gpw_lines_model
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking testbench of the GPIO port
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin err_total++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb_top
  import gpw_pkg::*;
();
  localparam int TK = 4;
  logic         pclk;
  logic         presetn;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [31:0]  paddr;
  logic [31:0]  pwdata;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         irq;
  gpw_mask_type line_in;
  gpw_mask_type line_out;
  gpw_mask_type line_oe;
  gpw_mask_type ext_val;
  logic [31:0]  rd;
  logic         er;
  int           err_total;
  int           check_count;

  gpw_port #(.TICK_CYCLES(TK)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .line_in(line_in),
    .line_out(line_out), .line_oe(line_oe));
  gpw_lines_model u_lines (.line_out(line_out), .line_oe(line_oe), .ext_val(ext_val),
    .line_in(line_in));

  always #25 pclk = ~pclk;

  // ************************************************************
  // Bus cycles and waits
  // ************************************************************
  task automatic summarize();
    if (err_total == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {24'h000000, a};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin err_total++; summarize(); end
  endtask

  task automatic look();
    repeat (2) @(negedge pclk);
  endtask

  task automatic wait_irq(output int c);
    c = 0;
    while (irq !== 1'b1 && c < 400) begin
      @(posedge pclk);
      c++;
    end
    if (irq !== 1'b1) begin err_total++; summarize(); end
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    `CHK("oe", 16'h0000, line_oe)
    apb(1'b0, A_DIR, 32'h0);
    `CHK("dir", 32'h00000000, rd)
    apb(1'b0, A_AVAIL, 32'h0);
    `CHK("avail", 32'h00000000, rd)
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 1'b1, er)
  endtask

  task automatic t_cache();
    apb(1'b1, A_DIR, 32'h000000FF);
    apb(1'b1, A_OUT, 32'h000000A5);
    look();
    `CHK("oe off", 16'h0000, line_oe)
    apb(1'b0, A_IN, 32'h0);
    `CHK("in off", 32'h00000000, rd)
    apb(1'b1, A_CFG, 32'h00000001);
    look();
    `CHK("oe on", 16'h00FF, line_oe)
    `CHK("drive", 16'h00A5, line_out & line_oe)
    `CHK("wire", 16'h00A5, line_in & 16'h00FF)
    apb(1'b0, A_IN, 32'h0);
    `CHK("in", 32'h00005A00, rd)
    apb(1'b0, A_AVAIL, 32'h0);
    `CHK("avail", 32'h0000FFFF, rd)
  endtask

  task automatic t_serial();
    apb(1'b1, A_SERIAL, 32'h00000F00);
    apb(1'b1, A_DIR, 32'h00000FFF);
    look();
    `CHK("oe held", 16'h00FF, line_oe)
    apb(1'b0, A_AVAIL, 32'h0);
    `CHK("avail", 32'h0000F0FF, rd)
    apb(1'b0, A_IN, 32'h0);
    `CHK("in serial", 32'h00005000, rd)
    apb(1'b1, A_SERIAL, 32'h0);
    look();
    `CHK("oe freed", 16'h0FFF, line_oe)
  endtask

  task automatic t_wait();
    int c;
    apb(1'b1, A_MASK, 32'h00000001);
    apb(1'b1, A_WAIT, 32'h00000064);
    wait_irq(c);
    `CHK("first fast", 1'b1, c < 10)
    apb(1'b0, A_WAIT, 32'h0);
    `CHK("first view", 32'h00005000, rd)
    apb(1'b1, A_MASK, 32'h0);
    look();
    `CHK("masked", 1'b0, irq)
    apb(1'b1, A_STAT, 32'h00000001);
    apb(1'b1, A_MASK, 32'h00000001);
    apb(1'b1, A_WAIT, 32'h00000064);
    apb(1'b1, A_WAIT, 32'h00000064);
    `CHK("busy", 1'b1, er)
    ext_val <= 16'h5A5B;
    repeat (30) @(posedge pclk);
    `CHK("out ignored", 1'b0, irq)
    ext_val <= 16'h4A5B;
    wait_irq(c);
    `CHK("change fast", 1'b1, c < 10)
    apb(1'b0, A_WAIT, 32'h0);
    `CHK("change view", 32'h00004000, rd)
    apb(1'b1, A_STAT, 32'h00000001);
    apb(1'b1, A_WAIT, 32'h00000003);
    wait_irq(c);
    `CHK("expiry", 1'b1, c >= 3 * TK && c <= 4 * TK + 8)
    apb(1'b0, A_WAIT, 32'h0);
    `CHK("expiry view", 32'h00004000, rd)
    apb(1'b1, A_STAT, 32'h00000003);
  endtask

  task automatic t_queue();
    logic [31:0] q [5];
    int          c;
    q = '{32'h000000F0, 32'h00010030, 32'h00020000, 32'h00030032, 32'h00020000};
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, A_QPUSH, q[i]);
      `CHK("push refused", i == 4, er)
    end
    look();
    `CHK("held", 16'h0FFF, line_oe)
    apb(1'b0, A_QPUSH, 32'h0);
    `CHK("count", 32'h00000004, rd)
    apb(1'b1, A_MASK, 32'h00000002);
    apb(1'b1, A_QSUB, 32'h0);
    wait_irq(c);
    look();
    `CHK("q oe", 16'h00F0, line_oe)
    `CHK("q drive", 16'h0030, line_out & line_oe)
    for (int i = 0; i < 2; i++) begin
      apb(1'b0, A_QRESP, 32'h0);
      `CHK("resp", 32'h00014A0B, rd)
    end
    apb(1'b0, A_QRESP, 32'h0);
    `CHK("resp empty", 1'b0, rd[RESP_VALID])
  endtask

  initial begin
    pclk        = 1'b0;
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 32'h0;
    pwdata      = 32'h0;
    ext_val     = 16'h5A5A;
    err_total   = 0;
    check_count = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_cache();
    t_serial();
    t_wait();
    t_queue();
    summarize();
  end
endmodule : tb_top
`default_nettype wire
